// ===== slave_window_params.svh
// offsets, field positions, reset values and window constants of the slave window map
`ifndef SLAVE_WINDOW_PARAMS_SVH
`define SLAVE_WINDOW_PARAMS_SVH

// ----------------------------------------------------------------
// register offset within the host i/o block
// ----------------------------------------------------------------
`define MAP_REG_OFFSET      4'h2

// ----------------------------------------------------------------
// field positions of the slave window map register
// ----------------------------------------------------------------
`define OFFSET_MSB          11
`define OFFSET_LSB          8
`define WIDE_EN_BIT         7
`define WIDE_SIZE_MSB       6
`define WIDE_SIZE_LSB       4
`define SHORT_EN_BIT        3
`define SHORT_SIZE_MSB      2
`define SHORT_SIZE_LSB      0

// ----------------------------------------------------------------
// base address field positions in the base address word
// ----------------------------------------------------------------
`define WIDE_BASE_MSB       15
`define WIDE_BASE_LSB       9
`define SHORT_BASE_MSB      7
`define SHORT_BASE_LSB      1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OFFSET_RESET        4'h0
`define WIDE_EN_RESET       1'h0
`define SHORT_EN_RESET      1'h0
`define SIZE_RESET          3'h0

// ----------------------------------------------------------------
// short space: top quarter holds the board's own config registers
// ----------------------------------------------------------------
`define CFG_QUARTER         2'h3

`endif

// ===== slave_window_pkg.sv
// types shared by the slave window mapping logic
package slave_window_pkg;

    typedef enum logic [1:0]
    {
        SPACE_NONE  = 2'b00,
        SPACE_WIDE  = 2'b01,
        SPACE_SHORT = 2'b10
    } space_type;

    typedef struct packed
    {
        logic [3:0] wide_window_offset;
        logic       wide_window_enable;
        logic [2:0] wide_window_size_code;
        logic       short_window_enable;
        logic [2:0] short_window_size_code;
    } window_map_type;

    typedef struct packed
    {
        logic        valid;
        space_type   space;
        logic [23:0] addr;
    } bus_cycle_type;

    typedef struct packed
    {
        logic        mem_req;
        logic        io_req;
        logic        cfg_hit;
        logic [23:0] addr;
    } host_cycle_type;

    typedef struct packed
    {
        window_map_type map;
        host_cycle_type host;
    } state_type;

endpackage

// ===== slave_window_mapping.sv
// slave window mapping register and expansion bus window decode
`timescale 1ns/1ns
`default_nettype none
`include "slave_window_params.svh"

// Notes on behaviour
// - map register at i/o offset 2, write-only
// - byte or word writes, only addressed bytes
// - offset adds to bus address bits 23-20
// - carry out of the offset add dropped
// - hard reset clears the wide offset
// - wide enable lets window cycles reach memory
// - wide disabled answers no wide addresses
// - wide window size two to 24-m
// - short enable lets window cycles reach i/o
// - short disabled answers only config quarter
// - short window size two to 16-n
// - wide base compares top m address bits
// - short base compares top n address bits
module slave_window_mapping
    import slave_window_pkg::*;
#(
    parameter int IO_ADDR_W = 4
)
(
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    // host i/o write port
    input  wire logic [IO_ADDR_W-1:0] io_addr,
    input  wire logic                 io_wr,
    input  wire logic                 io_be_even,
    input  wire logic                 io_be_odd,
    input  wire logic [15:0]          io_wdata,
    // base address word from the base address register
    input  wire logic [15:0]          slave_base_address_bits,
    // expansion bus cycle in
    input  wire bus_cycle_type        bus_cycle,
    // host bus cycle out
    output var  host_cycle_type       host_cycle,
    // current map, for the rest of the board
    output var  window_map_type       window_map
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // field widths as the header places them
    localparam int OFFSET_W = `OFFSET_MSB - `OFFSET_LSB + 1;
    localparam int WSIZE_W  = `WIDE_SIZE_MSB - `WIDE_SIZE_LSB + 1;
    localparam int SSIZE_W  = `SHORT_SIZE_MSB - `SHORT_SIZE_LSB + 1;
    localparam int WBASE_W  = `WIDE_BASE_MSB - `WIDE_BASE_LSB + 1;
    localparam int SBASE_W  = `SHORT_BASE_MSB - `SHORT_BASE_LSB + 1;

    generate
        if (IO_ADDR_W < 2)
        begin : g_bad_width
            $error("IO_ADDR_W too narrow to reach the map register");
        end
        // header and map struct must agree, or lanes land in wrong fields
        if ((OFFSET_W != 4) || (WSIZE_W != 3) || (SSIZE_W != 3))
        begin : g_bad_fields
            $error("map field positions do not match the map struct");
        end
        if ($bits(window_map_type) != (`OFFSET_MSB + 1))
        begin : g_bad_map
            $error("map struct does not fill the stored map bits");
        end
        // the size compare masks a fixed seven-bit base field
        if ((WBASE_W != 7) || (SBASE_W != 7))
        begin : g_bad_base
            $error("base address fields must be seven bits wide");
        end
    endgenerate

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // keeps the top 'bits' of a seven-bit base field
    function automatic logic [6:0] top_mask(input logic [2:0] bits);
        top_mask = ~(7'h7f >> bits);
    endfunction

    // address field matches base wherever the mask is set
    function automatic logic base_match(input logic [6:0] addr_f,
                                        input logic [6:0] base_f,
                                        input logic [2:0] bits);
        base_match = ((addr_f ^ base_f) & top_mask(bits)) == 7'h00;
    endfunction

    // a live expansion bus cycle in the given address space
    function automatic logic in_space(input bus_cycle_type cyc,
                                      input space_type     sp);
        in_space = cyc.valid && (cyc.space == sp);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_type state_q;
    state_type state_d;

    logic       map_sel;
    logic       odd_we;
    logic       even_we;
    logic       wide_hit;
    logic       short_hit;
    logic       cfg_quarter;
    logic [3:0] moved_top;
    logic [6:0] wide_base;
    logic [6:0] short_base;

    // base word and bus cycle come from same-clock logic: no synchroniser
    assign wide_base  = slave_base_address_bits[`WIDE_BASE_MSB:`WIDE_BASE_LSB];
    assign short_base = slave_base_address_bits[`SHORT_BASE_MSB:`SHORT_BASE_LSB];

    // ----------------------------------------------------------------
    // register write decode
    // ----------------------------------------------------------------
    // only a write is decoded; reads of this offset get nothing back
    assign map_sel = io_wr && (io_addr == IO_ADDR_W'(`MAP_REG_OFFSET));

    // per-lane strobes: a byte write leaves the other lane untouched
    assign odd_we  = map_sel && io_be_odd;
    assign even_we = map_sel && io_be_even;

    // ----------------------------------------------------------------
    // wide window decode
    // ----------------------------------------------------------------
    always_comb
    begin
        // size code m selects how many top bits take part in the compare
        wide_hit = in_space(bus_cycle, SPACE_WIDE)
                   && state_q.map.wide_window_enable
                   && base_match(bus_cycle.addr[23:17], wide_base,
                                 state_q.map.wide_window_size_code);
        // four-bit sum wraps, so the offset acts as two's complement
        moved_top = bus_cycle.addr[23:20] + state_q.map.wide_window_offset;
    end

    // ----------------------------------------------------------------
    // short window decode
    // ----------------------------------------------------------------
    always_comb
    begin
        cfg_quarter = in_space(bus_cycle, SPACE_SHORT)
                      && (bus_cycle.addr[15:14] == `CFG_QUARTER);
        // config quarter always belongs to the board, never forwarded
        short_hit = in_space(bus_cycle, SPACE_SHORT)
                    && state_q.map.short_window_enable && !cfg_quarter
                    && base_match(bus_cycle.addr[15:9], short_base,
                                  state_q.map.short_window_size_code);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (odd_we)
        begin
            // bits 15-12 are reserved and simply not stored
            state_d.map.wide_window_offset = io_wdata[`OFFSET_MSB:`OFFSET_LSB];
        end
        if (even_we)
        begin
            state_d.map.wide_window_enable     = io_wdata[`WIDE_EN_BIT];
            state_d.map.wide_window_size_code  = io_wdata[`WIDE_SIZE_MSB:`WIDE_SIZE_LSB];
            state_d.map.short_window_enable    = io_wdata[`SHORT_EN_BIT];
            state_d.map.short_window_size_code = io_wdata[`SHORT_SIZE_MSB:`SHORT_SIZE_LSB];
        end
        state_d.host.mem_req = wide_hit;
        state_d.host.io_req  = short_hit;
        state_d.host.cfg_hit = cfg_quarter;
        // misses leave the address at zero and raise no request
        if (wide_hit)
        begin
            state_d.host.addr = {moved_top, bus_cycle.addr[19:0]};
        end
        else if (short_hit)
        begin
            state_d.host.addr = {8'h00, bus_cycle.addr[15:0]};
        end
        else
        begin
            state_d.host.addr = 24'h000000;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset acts whatever ce says, so a held-off enable cannot keep old windows
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q.map.wide_window_offset     <= `OFFSET_RESET;
            state_q.map.wide_window_enable     <= `WIDE_EN_RESET;
            state_q.map.wide_window_size_code  <= `SIZE_RESET;
            state_q.map.short_window_enable    <= `SHORT_EN_RESET;
            state_q.map.short_window_size_code <= `SIZE_RESET;
            state_q.host                       <= '0;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    assign host_cycle = state_q.host;
    assign window_map = state_q.map;

endmodule // slave_window_mapping

`default_nettype wire

// ===== slave_window_mapping_props.sv
// checker for the slave window mapping ports
`timescale 1ns/1ns
`default_nettype none
module slave_window_mapping_props
    import slave_window_pkg::*;
#(
    parameter int IO_ADDR_W = 4
)
(
    // clock and control
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 ce,
    // host write port
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic                 io_wr,
    input wire logic                 io_be_even,
    input wire logic                 io_be_odd,
    input wire logic [15:0]          io_wdata,
    input wire logic [15:0]          slave_base_address_bits,
    // bus side
    input wire bus_cycle_type        bus_cycle,
    input wire host_cycle_type       host_cycle,
    input wire window_map_type       window_map
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic wr2 = ce && io_wr && io_addr == 'h2;
    wire logic ws  = ce && bus_cycle.valid && bus_cycle.space == SPACE_WIDE;
    wire logic sh  = ce && bus_cycle.valid && bus_cycle.space == SPACE_SHORT;
    a_reset_clear: assert property ($fell(reset) |-> window_map == '0)
        else $error("map not clear after reset");
    a_word_write: assert property (wr2 && io_be_odd && io_be_even
        |=> window_map == $past(io_wdata[11:0])) else $error("word write lost");
    a_odd_byte: assert property (wr2 && io_be_odd && !io_be_even
        |=> window_map[7:0] == $past(window_map[7:0])) else $error("low byte disturbed");
    a_other_addr: assert property (io_wr && io_addr != 'h2 |=> $stable(window_map))
        else $error("foreign write changed map");
    a_wide_fwd: assert property (ws && window_map[7:4] == 4'h8 |=> host_cycle.mem_req
        && host_cycle.addr == {$past(bus_cycle.addr[23:20]) + $past(window_map[11:8]),
        $past(bus_cycle.addr[19:0])}) else $error("wide address wrong");
    a_wide_quiet: assert property (!window_map.wide_window_enable && !io_wr
        |=> !host_cycle.mem_req) else $error("memory cycle while disabled");
    a_short_quiet: assert property (!window_map.short_window_enable && !io_wr
        |=> !host_cycle.io_req) else $error("io cycle while disabled");
    a_cfg_quarter: assert property (sh && bus_cycle.addr[15:14] == 2'h3
        |=> host_cycle.cfg_hit && !host_cycle.io_req) else $error("config quarter wrong");
    a_idle_quiet: assert property (ce && !bus_cycle.valid
        |=> !host_cycle.mem_req && !host_cycle.io_req) else $error("cycle from idle bus");
    c_wide: cover property (ws && window_map.wide_window_enable);
    c_cfg: cover property (sh && bus_cycle.addr[15:14] == 2'h3);
    c_odd: cover property (wr2 && io_be_odd && !io_be_even);
endmodule // slave_window_mapping_props
`default_nettype wire

// ===== expansion_master.sv
// expansion bus master issuing single window cycles
`timescale 1ns/1ns
`default_nettype none
module expansion_master
    import slave_window_pkg::*;
(
    // clock
    input  wire logic    clk,
    // cycle toward the block
    output var  bus_cycle_type bus_cycle
);
    initial bus_cycle = '0;
    task automatic issue(input space_type sp, input logic [23:0] a);
        bus_cycle = '{1'b1, sp, a};
        @(posedge clk);
        #1;
    endtask
    // released address inverted so a stale value never passes for a live one
    task automatic idle();
        bus_cycle = '{1'b0, SPACE_NONE, ~bus_cycle.addr};
    endtask
endmodule // expansion_master
`default_nettype wire

// ===== slave_window_mapping_tb.sv
// self-checking bench for the slave window mapping
`timescale 1ns/1ns
`default_nettype none
module slave_window_mapping_tb
    import slave_window_pkg::*;
;
    logic           clk = 0, reset = 1, ce = 1, io_wr = 0, be_e = 0, be_o = 0;
    logic [3:0]     io_addr = '0;
    logic [15:0]    wd = '0, base = '0;
    int             errors = 0, n_tests = 0, cyc = 0;
    bus_cycle_type  bc;
    host_cycle_type hc;
    window_map_type wm;
    expansion_master master (.clk(clk), .bus_cycle(bc));
    slave_window_mapping #(.IO_ADDR_W(4)) DUT (.clk(clk), .reset(reset), .ce(ce),
        .io_addr(io_addr), .io_wr(io_wr), .io_be_even(be_e), .io_be_odd(be_o),
        .io_wdata(wd), .slave_base_address_bits(base), .bus_cycle(bc),
        .host_cycle(hc), .window_map(wm));
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        n_tests++;
        if (e !== g)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic o, logic e, logic [3:0] a, logic [15:0] d);
        {be_o, be_e, io_addr, wd, io_wr} = {o, e, a, d, 1'b1};
        @(posedge clk);
        #1 io_wr = 0;
        @(posedge clk);
        #1;
    endtask
    // misses and config hits must leave the host address at zero
    task automatic probe(space_type sp, logic [23:0] a, logic [2:0] f, logic [23:0] ea);
        master.issue(sp, a);
        chk("host flags", {21'h0, f}, {21'h0, hc.mem_req, hc.io_req, hc.cfg_hit});
        chk("host addr", ea, hc.addr);
    endtask
    task automatic wide_offset();
        wr(1, 1, 4'h2, 16'h0f88);
        chk("map word", 24'hf88, {12'h0, wm});
        probe(SPACE_WIDE, 24'h123456, 3'h4, 24'h023456);
        wr(1, 0, 4'h2, 16'h0200);
        chk("map odd byte", 24'h288, {12'h0, wm});
        wr(1, 1, 4'h3, 16'h0000);
        chk("map other addr", 24'h288, {12'h0, wm});
        probe(SPACE_WIDE, 24'hf00001, 3'h4, 24'h100001);
    endtask
    task automatic window_sizes();
        base = 16'h4000;
        wr(1, 1, 4'h2, 16'h00a9);
        probe(SPACE_WIDE, 24'h7fffff, 3'h4, 24'h7fffff);
        probe(SPACE_WIDE, 24'h800000, 3'h0, 24'h0);
        probe(SPACE_SHORT, 24'h007ffe, 3'h2, 24'h007ffe);
        probe(SPACE_SHORT, 24'h008000, 3'h0, 24'h0);
        probe(SPACE_SHORT, 24'h00c000, 3'h1, 24'h0);
        probe(SPACE_NONE, 24'h400000, 3'h0, 24'h0);
    endtask
    task automatic disabled();
        wr(1, 1, 4'h2, 16'h0077);
        probe(SPACE_WIDE, 24'h400000, 3'h0, 24'h0);
        probe(SPACE_SHORT, 24'h000010, 3'h0, 24'h0);
        probe(SPACE_SHORT, 24'h00ffff, 3'h1, 24'h0);
        master.idle();
    endtask
    // clock enable low: writes and bus decode are both held off
    task automatic frozen();
        ce = 0;
        wr(1, 1, 4'h2, 16'h0f88);
        chk("map frozen", 24'h077, {12'h0, wm});
        chk("host frozen", 24'h1, {21'h0, hc.mem_req, hc.io_req, hc.cfg_hit});
        ce = 1;
        wr(1, 1, 4'h2, 16'h0088);
        chk("map after enable", 24'h088, {12'h0, wm});
        chk("host after enable", 24'h0, {21'h0, hc.mem_req, hc.io_req, hc.cfg_hit});
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        #1 reset = 0;
        chk("map after reset", 24'h0, {12'h0, wm});
        wide_offset();
        window_sizes();
        disabled();
        frozen();
        wrap_up();
    end
endmodule // slave_window_mapping_tb
bind slave_window_mapping slave_window_mapping_props #(.IO_ADDR_W(IO_ADDR_W)) props (
    .clk(clk), .reset(reset), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
    .io_be_even(io_be_even), .io_be_odd(io_be_odd), .io_wdata(io_wdata),
    .slave_base_address_bits(slave_base_address_bits), .bus_cycle(bus_cycle),
    .host_cycle(host_cycle), .window_map(window_map));
`default_nettype wire
